/* File: hdl/spi_diag_pkg.sv */
// constants and types for the serial diagnosis port
package spi_diag_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 8'h07;
   localparam logic [CNT_W-1:0] CNT_MIN_FRAME = 8'h10;
   localparam logic [CNT_W-1:0] CNT_BYTE = 8'h08;
   localparam logic [2:0] BYTE_ALIGN = 3'h0;

   // ----------------------------------------------------------------
   // address byte fields
   // ----------------------------------------------------------------
   localparam int ADDR_TYPE_BIT = 7;
   localparam int ADDR_HI = 6;
   localparam int ADDR_LO = 2;
   localparam int ADDR_LAST_ADDRESS_TOKEN_BIT = 1;
   localparam int ADDR_ONE_BIT = 0;

   // register indices carried in the address field
   localparam logic [4:0] REG_GLOBAL = 5'h00;
   localparam logic [4:0] REG_OPEN_LOAD = 5'h01;
   localparam logic [4:0] REG_OVER_CUR = 5'h02;
   localparam logic [4:0] REG_CTRL_BASE = 5'h03;

   // ----------------------------------------------------------------
   // global fault summary bit positions
   // ----------------------------------------------------------------
   localparam int GS_PROTO = 7;
   localparam int GS_LOAD = 6;
   localparam int GS_SUPPLY_LOW = 5;
   localparam int GS_SUPPLY_HIGH = 4;
   localparam int GS_POWERUP = 3;
   localparam int GS_THERM_SD = 2;
   localparam int GS_THERM_WARN = 1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int ENABLE_SETTLE_TIME_NS = 10000;
   localparam int ENABLE_SETTLE_CYC = (ENABLE_SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_W = 16;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACTIVE = 3'b010,
      ST_IGNORE = 3'b100
   } frame_state_e;

endpackage

/* File: hdl/spi_pin_if.sv */
// synchronised serial pin levels and their edges
`timescale 1ns/1ns
interface spi_pin_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic en;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic en_rise;

   modport producer (output cs_n, sclk, sdi, en, cs_fall, cs_rise, sclk_rise, sclk_fall,
      en_rise);
   modport consumer (input cs_n, sclk, sdi, en, cs_fall, cs_rise, sclk_rise, sclk_fall,
      en_rise);
endinterface

/* File: hdl/spi_pin_sync.sv */
// two-stage pin synchronisers with edge detection
`timescale 1ns/1ns
module spi_pin_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // raw pins
   input wire logic chip_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic enable_i,
   // synchronised view
   spi_pin_if.producer pins
);

   localparam int NPIN = 4;
   localparam logic [NPIN-1:0] IDLE_LVL = 4'h1;

   logic [NPIN-1:0] raw;
   logic [NPIN-1:0] meta_r;
   logic [NPIN-1:0] sync_r;
   logic [NPIN-1:0] prev_r;

   assign raw = {enable_i, sdi_i, sclk_i, chip_select_n_i};

   // first stage feeds only the second; edges compare second and third
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= IDLE_LVL;
         sync_r <= IDLE_LVL;
         prev_r <= IDLE_LVL;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign pins.cs_n = sync_r[0];
   assign pins.sclk = sync_r[1];
   assign pins.sdi = sync_r[2];
   assign pins.en = sync_r[3];
   assign pins.cs_fall = prev_r[0] & ~sync_r[0];
   assign pins.cs_rise = ~prev_r[0] & sync_r[0];
   assign pins.sclk_rise = ~prev_r[1] & sync_r[1];
   assign pins.sclk_fall = prev_r[1] & ~sync_r[1];
   assign pins.en_rise = ~prev_r[3] & sync_r[3];

endmodule

/* File: hdl/spi_diag_port.sv */
// serial control and diagnosis port of an eight-output half-bridge driver
//
// Functional notes
// - serial input sampled into receive register on each clock falling edge.
// - serial output advances one transmit bit on each clock rising edge.
// - frame starts at select low; command decoded only after select rises.
// - serial output released to high impedance when select rises.
// - addressed register shifted out in the same frame as its command.
// - accesses are whole bytes; flags only cleared by host command.
// - frames starting before enable settle time are ignored.
// - before first rising edge output shows error flag OR serial input.
// - error flag set on any fault and after power-on reset.
// - select pulse without clocks reads the error flag.
// - first eight clocks shift out the global fault summary byte.
// - error flag is OR of fault bits and inverted power-up flag.
// - load fault bit is OR of all open-load and over-current flags.
// - after reset power-up flag is 0, other summary bits 0.
// - protocol error is summary bit 7, visible from the next frame.
// - nonzero clock count not a multiple of 8 or below 16 errs.
// - command to unused register address is a protocol error.
// - address byte least bit not 1 is a protocol error.
// - last-address token (address bit 1) not 1 is a protocol error.
// - clock high at either select edge is a protocol error.
// - address bit 7: 0 reads, 1 writes or reads-and-clears.
// - clear is dropped when a new fault hits that register mid-frame.
`timescale 1ns/1ns
module spi_diag_port
   import spi_diag_pkg::*;
#(
   parameter int NUM_OUT = 8,
   parameter int NUM_CTRL = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial pins
   input wire logic chip_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic enable_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   // fault sources
   input wire logic [NUM_OUT-1:0] open_load_fault_i,
   input wire logic [NUM_OUT-1:0] over_current_fault_i,
   input wire logic supply_low_flag_i,
   input wire logic supply_high_flag_i,
   input wire logic thermal_shutdown_flag_i,
   input wire logic thermal_warning_flag_i,
   // device view
   output logic any_fault_flag_o,
   output logic [7:0] global_fault_summary_o,
   output logic [NUM_CTRL*8-1:0] ctrl_o
);

   localparam logic [4:0] REG_LAST = 5'(REG_CTRL_BASE + NUM_CTRL - 1);

   spi_pin_if pins();

   spi_pin_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .chip_select_n_i(chip_select_n_i),
      .sclk_i(sclk_i),
      .sdi_i(sdi_i),
      .enable_i(enable_i),
      .pins(pins.producer)
   );

   frame_state_e state_r;
   logic [SETTLE_W-1:0] settle_cnt_r;
   logic settled_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [FRAME_BITS-1:0] rx_r;
   logic [FRAME_BITS-1:0] rx_nxt;
   logic [7:0] addr_r;
   logic [7:0] tx_r;
   logic started_r;
   logic pol_err_r;
   logic proto_r;
   logic supply_low_r;
   logic supply_high_r;
   logic therm_sd_r;
   logic therm_warn_r;
   logic powerup_r;
   logic [NUM_OUT-1:0] open_load_r;
   logic [NUM_OUT-1:0] over_cur_r;
   logic glob_evt_r;
   logic ol_evt_r;
   logic oc_evt_r;
   logic [7:0] ctrl_r [NUM_CTRL];
   logic [7:0] summary;
   logic any_fault_flag;
   logic [7:0] rd_byte;
   logic [4:0] rd_idx;
   logic [4:0] reg_idx;
   logic frame_end;
   logic count_err;
   logic addr_err;
   logic frame_err;
   logic exec;
   logic wr;
   logic clr_glob;
   logic clr_ol;
   logic clr_oc;
   logic accept;
   logic glob_in;

   // ----------------------------------------------------------------
   // status summary and error flag
   // ----------------------------------------------------------------
   always_comb begin
      summary = BYTE_ZERO;
      summary[GS_PROTO] = proto_r;
      summary[GS_LOAD] = (|open_load_r) | (|over_cur_r);
      summary[GS_SUPPLY_LOW] = supply_low_r;
      summary[GS_SUPPLY_HIGH] = supply_high_r;
      summary[GS_POWERUP] = powerup_r;
      summary[GS_THERM_SD] = therm_sd_r;
      summary[GS_THERM_WARN] = therm_warn_r;
   end

   // powerup_r low after reset raises the flag by itself
   assign any_fault_flag = summary[GS_PROTO] | summary[GS_LOAD] | supply_low_r | supply_high_r
      | ~powerup_r | therm_sd_r | therm_warn_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         any_fault_flag_o <= 1'b1;
         global_fault_summary_o <= BYTE_ZERO;
      end else begin
         any_fault_flag_o <= any_fault_flag;
         global_fault_summary_o <= summary;
      end
   end

   // ----------------------------------------------------------------
   // enable settle window
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         settle_cnt_r <= '0;
         settled_r <= 1'b0;
      end else if (!pins.en || pins.en_rise) begin
         settle_cnt_r <= '0;
         settled_r <= 1'b0;
      end else if (!settled_r) begin
         settle_cnt_r <= settle_cnt_r + 1'b1;
         if (settle_cnt_r == SETTLE_W'(ENABLE_SETTLE_CYC - 1)) begin
            settled_r <= 1'b1;
         end
      end
   end

   assign accept = settled_r & pins.en;

   // ----------------------------------------------------------------
   // frame state
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (pins.cs_fall) begin
                  state_r <= accept ? ST_ACTIVE : ST_IGNORE;
               end
            end
            ST_ACTIVE, ST_IGNORE: begin
               if (pins.cs_rise) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // shift registers
   // ----------------------------------------------------------------
   assign rx_nxt = {rx_r[FRAME_BITS-2:0], pins.sdi};
   assign rd_idx = rx_nxt[ADDR_HI:ADDR_LO];

   always_comb begin
      rd_byte = BYTE_ZERO;
      if (rd_idx == REG_GLOBAL) begin
         rd_byte = summary;
      end else if (rd_idx == REG_OPEN_LOAD) begin
         rd_byte = 8'(open_load_r);
      end else if (rd_idx == REG_OVER_CUR) begin
         rd_byte = 8'(over_cur_r);
      end
      for (int i = 0; i < NUM_CTRL; i++) begin
         if (rd_idx == 5'(REG_CTRL_BASE + i)) begin
            rd_byte = ctrl_r[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt_r <= CNT_ZERO;
         rx_r <= '0;
         addr_r <= BYTE_ZERO;
         tx_r <= BYTE_ZERO;
         started_r <= 1'b0;
         pol_err_r <= 1'b0;
      end else if (state_r == ST_IDLE && pins.cs_fall) begin
         bit_cnt_r <= CNT_ZERO;
         addr_r <= BYTE_ZERO;
         started_r <= 1'b0;
         pol_err_r <= pins.sclk;
         tx_r <= summary;
      end else if (state_r == ST_ACTIVE) begin
         if (pins.sclk_fall) begin
            rx_r <= rx_nxt;
            if (bit_cnt_r != CNT_MAX) begin
               bit_cnt_r <= bit_cnt_r + 1'b1;
            end
            if (bit_cnt_r == CNT_ADDR_DONE) begin
               addr_r <= rx_nxt[7:0];
               tx_r <= rd_byte;
            end
         end else if (pins.sclk_rise) begin
            started_r <= 1'b1;
            // later bits pass the received stream through for chaining
            tx_r <= {tx_r[6:0], rx_r[0]};
         end
      end
   end

   // ----------------------------------------------------------------
   // serial output
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sdo_o <= 1'b0;
         sdo_oe_n_o <= 1'b1;
      end else if (state_r == ST_IDLE && pins.cs_fall && accept) begin
         sdo_oe_n_o <= 1'b0;
         sdo_o <= any_fault_flag | pins.sdi;
      end else if (state_r == ST_ACTIVE) begin
         if (pins.cs_rise) begin
            sdo_oe_n_o <= 1'b1;
            sdo_o <= 1'b0;
         end else if (pins.sclk_rise) begin
            sdo_o <= tx_r[7];
         end else if (!started_r) begin
            sdo_o <= any_fault_flag | pins.sdi;
         end
      end
   end

   // ----------------------------------------------------------------
   // end-of-frame checks and command decode
   // ----------------------------------------------------------------
   assign frame_end = (state_r == ST_ACTIVE) && pins.cs_rise;
   assign reg_idx = addr_r[ADDR_HI:ADDR_LO];

   assign count_err = (bit_cnt_r != CNT_ZERO)
      && ((bit_cnt_r[2:0] != BYTE_ALIGN) || (bit_cnt_r < CNT_MIN_FRAME));

   // address checks only once a whole address byte has arrived
   assign addr_err = (bit_cnt_r >= CNT_BYTE)
      && (!addr_r[ADDR_ONE_BIT]
      || !addr_r[ADDR_LAST_ADDRESS_TOKEN_BIT]
      || (reg_idx > REG_LAST));

   assign frame_err = count_err | addr_err | pol_err_r | pins.sclk;

   // only a plain address+data frame executes; longer chained frames are only checked
   assign exec = frame_end && !frame_err && (bit_cnt_r == CNT_MIN_FRAME);
   assign wr = exec && addr_r[ADDR_TYPE_BIT];

   assign glob_in = supply_low_flag_i | supply_high_flag_i | thermal_shutdown_flag_i
      | thermal_warning_flag_i;

   assign clr_glob = wr && (reg_idx == REG_GLOBAL) && !glob_evt_r && !glob_in;
   assign clr_ol = wr && (reg_idx == REG_OPEN_LOAD) && !ol_evt_r
      && !(|open_load_fault_i);
   assign clr_oc = wr && (reg_idx == REG_OVER_CUR) && !oc_evt_r
      && !(|over_current_fault_i);

   // ----------------------------------------------------------------
   // new-fault tracking within a frame
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         glob_evt_r <= 1'b0;
         ol_evt_r <= 1'b0;
         oc_evt_r <= 1'b0;
      end else if (state_r == ST_IDLE && pins.cs_fall) begin
         glob_evt_r <= glob_in;
         ol_evt_r <= |open_load_fault_i;
         oc_evt_r <= |over_current_fault_i;
      end else begin
         glob_evt_r <= glob_evt_r | glob_in;
         ol_evt_r <= ol_evt_r | (|open_load_fault_i);
         oc_evt_r <= oc_evt_r | (|over_current_fault_i);
      end
   end

   // ----------------------------------------------------------------
   // sticky fault flags (set wins over clear)
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proto_r <= 1'b0;
         supply_low_r <= 1'b0;
         supply_high_r <= 1'b0;
         therm_sd_r <= 1'b0;
         therm_warn_r <= 1'b0;
         powerup_r <= 1'b0;
      end else begin
         // never self-clearing: only a whole-byte host clear drops them
         proto_r <= (frame_end && frame_err) | (proto_r & ~clr_glob);
         supply_low_r <= supply_low_flag_i | (supply_low_r & ~clr_glob);
         supply_high_r <= supply_high_flag_i | (supply_high_r & ~clr_glob);
         therm_sd_r <= thermal_shutdown_flag_i | (therm_sd_r & ~clr_glob);
         therm_warn_r <= thermal_warning_flag_i | (therm_warn_r & ~clr_glob);
         powerup_r <= powerup_r | clr_glob;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         open_load_r <= '0;
         over_cur_r <= '0;
      end else begin
         open_load_r <= open_load_fault_i | (open_load_r & ~{NUM_OUT{clr_ol}});
         over_cur_r <= over_current_fault_i | (over_cur_r & ~{NUM_OUT{clr_oc}});
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CTRL; g++) begin : g_ctrl
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            ctrl_r[g] <= BYTE_ZERO;
         end else if (wr && reg_idx == 5'(REG_CTRL_BASE + g)) begin
            ctrl_r[g] <= rx_r[7:0];
         end
      end
      assign ctrl_o[g*8 +: 8] = ctrl_r[g];
   end

endmodule

/* File: verification/spi_diag_port_monitor.sv */
// bound checker for the serial diagnosis port
`timescale 1ns/1ns
module spi_diag_port_monitor
   import spi_diag_pkg::*;
#(
   parameter int NUM_OUT = 8,
   parameter int NUM_CTRL = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial pins
   input wire logic chip_select_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   input wire logic enable_i,
   input wire logic sdo_o,
   input wire logic sdo_oe_n_o,
   // fault sources
   input wire logic [NUM_OUT-1:0] open_load_fault_i,
   input wire logic [NUM_OUT-1:0] over_current_fault_i,
   input wire logic supply_low_flag_i,
   input wire logic supply_high_flag_i,
   input wire logic thermal_shutdown_flag_i,
   input wire logic thermal_warning_flag_i,
   // device view
   input wire logic any_fault_flag_o,
   input wire logic [7:0] global_fault_summary_o,
   input wire logic [NUM_CTRL*8-1:0] ctrl_o
);
   // ----------------------------------------------------------------
   // cycles since select went high, saturating
   // ----------------------------------------------------------------
   logic [7:0] hi_cnt_r;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_cnt_r <= 8'hFF;
      end else if (!chip_select_n_i) begin
         hi_cnt_r <= 8'h00;
      end else if (hi_cnt_r != 8'hFF) begin
         hi_cnt_r <= hi_cnt_r + 8'h01;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence frame_open;
      $fell(chip_select_n_i) && !sclk_i;
   endsequence
   sequence early_out;
      ##5 (sdo_oe_n_o || sdo_o == any_fault_flag_o);
   endsequence

   chk_early_flag: assert property (frame_open |-> early_out)
      else $error("early output differs from error flag");
   chk_oe_release: assert property ($rose(chip_select_n_i) |-> ##[1:6] sdo_oe_n_o)
      else $error("output not released after select rise");
   chk_oe_idle: assert property (!sdo_oe_n_o |-> hi_cnt_r < 8'h06)
      else $error("output driven outside a frame");
   chk_flag_reset: assert property ($rose(rst_n_i) |->
      any_fault_flag_o && global_fault_summary_o == 8'h00)
      else $error("wrong flag or summary after reset");
   chk_flag_or: assert property (any_fault_flag_o == (|(global_fault_summary_o & 8'hF6)
      || !global_fault_summary_o[GS_POWERUP]))
      else $error("error flag not the OR of summary bits");
   chk_load_or: assert property ((|open_load_fault_i || |over_current_fault_i)
      |-> ##[1:3] global_fault_summary_o[GS_LOAD])
      else $error("load bit not set by output fault");
   chk_sticky_hold: assert property (|(~global_fault_summary_o
      & $past(global_fault_summary_o) & 8'hF6) |-> hi_cnt_r < 8'h08)
      else $error("summary bit cleared without a frame");
   chk_proto_late: assert property ($rose(global_fault_summary_o[GS_PROTO])
      |-> hi_cnt_r > 8'h00 && hi_cnt_r < 8'h08)
      else $error("protocol error set outside frame end");
   chk_ctrl_late: assert property ($changed(ctrl_o)
      |-> hi_cnt_r > 8'h00 && hi_cnt_r < 8'h08)
      else $error("control write not at frame end");
endmodule

bind spi_diag_port spi_diag_port_monitor #(.NUM_OUT(NUM_OUT), .NUM_CTRL(NUM_CTRL))
   u_spi_diag_port_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .enable_i(enable_i),
   .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .open_load_fault_i(open_load_fault_i),
   .over_current_fault_i(over_current_fault_i), .supply_low_flag_i(supply_low_flag_i),
   .supply_high_flag_i(supply_high_flag_i), .thermal_shutdown_flag_i(thermal_shutdown_flag_i),
   .thermal_warning_flag_i(thermal_warning_flag_i), .any_fault_flag_o(any_fault_flag_o),
   .global_fault_summary_o(global_fault_summary_o), .ctrl_o(ctrl_o));

/* File: verification/spi_host_model.sv */
// serial master model driving the diagnosis port
`timescale 1ns/1ns
module spi_host_model (
   // clock
   input wire logic clk_i,
   // serial lines
   output logic chip_select_n_o,
   output logic sclk_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_n_i
);
   logic in_frame;
   initial begin
      chip_select_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      in_frame = 1'b0;
   end
   // data line has no pull: keep it moving between frames
   always @(posedge clk_i) begin
      if (!in_frame) sdi_o <= #5 ~sdi_o;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask
   // half period of 4 clocks gives the 400 ns serial clock
   task automatic xfer(input logic [15:0] tx, input int nbits, input bit cpol_bad,
         output logic [15:0] rx);
      rx = 16'h0000;
      // stop the idle toggling first, so no pending toggle overwrites the low level
      in_frame = 1'b1;
      wait_clk(1);
      sdi_o = 1'b0;
      sclk_o = cpol_bad;
      wait_clk(4);
      chip_select_n_o = 1'b0;
      wait_clk(8);
      sclk_o = 1'b0;
      rx[0] = sdo_oe_n_i ? 1'b0 : sdo_i;
      for (int i = 0; i < nbits; i++) begin
         sclk_o = 1'b1;
         sdi_o = tx[15 - (i % 16)];
         wait_clk(4);
         sclk_o = 1'b0;
         wait_clk(4);
         rx = {rx[14:0], sdo_oe_n_i ? ~rx[0] : sdo_i};
      end
      wait_clk(4);
      chip_select_n_o = 1'b1;
      wait_clk(8);
      in_frame = 1'b0;
   endtask
endmodule

/* File: verification/test_spi_diag_port.sv */
// self-checking bench for the serial diagnosis port
`timescale 1ns/1ns
module test_spi_diag_port
   import spi_diag_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cs_n, sclk, sdi, sdo, sdo_oe_n, any_fault;
   logic enable = 1'b0;
   logic [7:0] open_load = 8'h00;
   logic [7:0] over_cur = 8'h00;
   logic [3:0] sticky = 4'h0;
   logic [7:0] summary;
   logic [31:0] ctrl;
   logic [15:0] rx;
   int bad_count = 0;
   int n_tests = 0;
   logic [7:0] ea [6] = '{8'h0F, 8'h0F, 8'hFF, 8'h8E, 8'h8D, 8'h8F};
   int en [6] = '{12, 8, 16, 16, 16, 16};
   bit eb [6] = '{0, 0, 0, 0, 0, 1};
   int pos [4] = '{GS_THERM_WARN, GS_THERM_SD, GS_SUPPLY_HIGH, GS_SUPPLY_LOW};

   always #25 clk_i = ~clk_i;

   spi_diag_port u_spi_diag_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(cs_n),
      .sclk_i(sclk), .sdi_i(sdi), .enable_i(enable), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
      .open_load_fault_i(open_load), .over_current_fault_i(over_cur),
      .supply_low_flag_i(sticky[3]), .supply_high_flag_i(sticky[2]),
      .thermal_shutdown_flag_i(sticky[1]), .thermal_warning_flag_i(sticky[0]),
      .any_fault_flag_o(any_fault), .global_fault_summary_o(summary), .ctrl_o(ctrl));
   spi_host_model u_spi_host_model (.clk_i(clk_i), .chip_select_n_o(cs_n), .sclk_o(sclk),
      .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [7:0] abyte(input logic op, input logic [4:0] idx);
      return {op, idx, 1'b1, 1'b1};
   endfunction
   task automatic frm(input logic [7:0] a, input logic [7:0] d, input int n = 16,
         input bit bad = 1'b0);
      u_spi_host_model.xfer({a, d}, n, bad, rx);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      #2000000;
      bad_count++;
      $display("watchdog expired");
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      tick(8);
      rst_n_i = 1'b1;
      tick(1);
      check("flag", 16'h0001, {15'h0, any_fault});
      check("summary", 16'h0000, {8'h00, summary});
      enable = 1'b1;
      frm(abyte(1'b1, REG_CTRL_BASE), 8'hA5);
      check("ctrl", 16'h0000, ctrl[15:0]);
      check("summary", 16'h0000, {8'h00, summary});
      tick(ENABLE_SETTLE_CYC);
      $display("test settle done");
      frm(8'h00, 8'h00, 0);
      check("flag read", 16'h0001, rx);
      frm(abyte(1'b1, REG_GLOBAL), 8'h00);
      check("clear rx", 16'h0000, rx);
      check("summary", 16'h0008, {8'h00, summary});
      frm(8'h00, 8'h00, 0);
      check("flag read", 16'h0000, rx);
      frm(abyte(1'b1, REG_CTRL_BASE), 8'h5A);
      check("write rx", 16'h0800, rx);
      check("ctrl", 16'h005A, ctrl[15:0]);
      check("ctrl upper", 16'h0000, ctrl[31:16]);
      frm(abyte(1'b0, REG_CTRL_BASE), 8'h00);
      check("read rx", 16'h085A, rx);
      check("ctrl", 16'h005A, ctrl[15:0]);
      $display("test access done");
      for (int i = 0; i < 6; i++) begin
         frm(ea[i], 8'h11, en[i], eb[i]);
         check("error bit", 16'h0001, {15'h0, summary[GS_PROTO]});
         check("ctrl kept", 16'h005A, ctrl[15:0]);
         check("flag", 16'h0001, {15'h0, any_fault});
         frm(abyte(1'b1, REG_GLOBAL), 8'h00);
         check("next frame", 16'h8888, rx);
         check("summary", 16'h0008, {8'h00, summary});
      end
      $display("test protocol done");
      for (int i = 0; i < 4; i++) begin
         sticky[i] = 1'b1;
         tick(1);
         sticky[i] = 1'b0;
         tick(4);
         check("flag", 16'h0001, {15'h0, any_fault});
         frm(abyte(1'b0, REG_GLOBAL), 8'h00);
         check("read rx", {2{8'h08 | (8'h01 << pos[i])}}, rx);
         check("kept", {8'h00, 8'h08 | (8'h01 << pos[i])}, {8'h00, summary});
         frm(abyte(1'b1, REG_GLOBAL), 8'h00);
         check("summary", 16'h0008, {8'h00, summary});
      end
      for (int k = 0; k < 2; k++) begin
         if (k == 0) open_load = 8'h04;
         else over_cur = 8'h80;
         tick(1);
         open_load = 8'h00;
         over_cur = 8'h00;
         tick(4);
         check("load bit", 16'h0001, {15'h0, summary[GS_LOAD]});
         frm(abyte(1'b0, k ? REG_OVER_CUR : REG_OPEN_LOAD), 8'h00);
         check("load reg", k ? 16'h4880 : 16'h4804, rx);
         frm(abyte(1'b1, k ? REG_OVER_CUR : REG_OPEN_LOAD), 8'h00);
         check("summary", 16'h0008, {8'h00, summary});
      end
      $display("test faults done");
      fork
         frm(abyte(1'b1, REG_GLOBAL), 8'h00);
         begin
            tick(100);
            sticky[0] = 1'b1;
            tick(1);
            sticky[0] = 1'b0;
         end
      join
      check("new fault", 16'h0001, {15'h0, summary[GS_THERM_WARN]});
      frm(abyte(1'b1, REG_GLOBAL), 8'h00);
      check("summary", 16'h0008, {8'h00, summary});
      $display("test clear race done");
      tally_and_finish();
   end
endmodule
